// file: hw/ext_irq_edge_latch_ctrl.sv
// external request edge controller: host interrupt and port latch strobes
// assumes AHB-Lite single word transfers and pins on group 3 lines c7/c6
// How it works
// - one edge strobes all twelve ports together
// - no per-port interrupt routing or status
// - pending set blocks new edges
// - first blocked edge sets missed flag
// - rise and fall record bits kept
// - host interrupt raised per interrupt transfer
// - enable bit 12 clear stops interrupts
// - polarity bit 6 picks interrupt edge
// - latch enable bit 5, edge bit 6
// - edge status bit 17 set when an edge is accepted
// - gate high: no interrupt, no latch
// - rising edge is reset default
// - c7/c6 pick interrupt role or plain I/O
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module ext_irq_edge_latch_ctrl
  import ext_irq_pkg::*;
(
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic      [31:0]                         hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  input  wire logic                                group3_line_c7_in,
  output logic                                     group3_line_c7_out,
  output logic                                     group3_line_c7_oe,
  input  wire logic                                group3_line_c6_in,
  output logic                                     group3_line_c6_out,
  output logic                                     group3_line_c6_oe,
  output logic                                     irq_to_host,
  output logic      [ext_irq_pkg::NUM_PORTS-1:0]   port_transfer,
  output logic      [ext_irq_pkg::NUM_PORTS-1:0]   port_latch
);
  import ext_irq_pkg::*;

  // bus state
  bus_state_t  state;
  bus_state_t  next_state;
  logic        wr_pending;
  logic [7:0]  dp_addr;
  logic        addr_phase;
  logic        rd_start;
  logic [31:0] rd_value;

  // control and status
  logic        int_enable;
  logic        polarity;
  logic        latch_enable;
  logic        latch_edge;
  logic [9:0]  line_cfg;
  logic        pending;
  logic        missed;
  logic        rec_rise;
  logic        rec_fall;
  logic        edge_status;
  logic        irq_raised;
  logic        transfer_q;
  logic        latch_q;

  req_line_if lines ();

  req_line_sync u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .raw_lines ({group3_line_c6_in, group3_line_c7_in}),
    .role_gate (line_cfg[BIT_C7_IRQ_ROLE]),
    .role_req  (line_cfg[BIT_C6_IRQ_ROLE]),
    .lines     (lines)
  );

  // ---------------- bus slave ----------------
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_start   = addr_phase & ~hwrite;
  assign hreadyout  = (state != BUS_READ_WAIT);
  assign hresp      = 1'b0;

  // reads take one wait so a write in flight lands first
  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE:      if (rd_start) next_state = BUS_READ_WAIT;
      BUS_READ_WAIT: next_state = BUS_READ_DONE;
      BUS_READ_DONE: next_state = rd_start ? BUS_READ_WAIT : BUS_IDLE;
      default:       next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= BUS_IDLE;
      wr_pending <= 1'b0;
      dp_addr    <= 8'h00;
    end else begin
      state      <= next_state;
      wr_pending <= addr_phase & hwrite;
      if (addr_phase) dp_addr <= haddr[7:0];
    end
  end

  wire wr_csr   = wr_pending && (dp_addr == ADDR_IRQ_CSR);
  wire wr_group = wr_pending && (dp_addr == ADDR_GROUP_CTRL);
  wire wr_line  = wr_pending && (dp_addr == ADDR_LINE_CFG);

  wire [31:0] csr_view =
      (32'(pending)     << BIT_PENDING)    |
      (32'(missed)      << BIT_MISSED)     |
      (32'(rec_rise)    << BIT_REC_RISE)   |
      (32'(rec_fall)    << BIT_REC_FALL)   |
      (32'(polarity)    << BIT_POLARITY)   |
      (32'(int_enable)  << BIT_INT_ENABLE) |
      (32'(edge_status) << BIT_EDGE_STATUS);
  wire [31:0] group_view =
      (32'(latch_enable) << BIT_LATCH_ENABLE) |
      (32'(latch_edge)   << BIT_LATCH_EDGE);
  wire [31:0] state_view =
      {28'h0000000, lines.req_level, lines.gate_level,
       lines.gate_active, irq_to_host};

  // unmapped offsets read as zero
  assign rd_value = (dp_addr == ADDR_IRQ_CSR)    ? csr_view   :
                    (dp_addr == ADDR_GROUP_CTRL) ? group_view :
                    (dp_addr == ADDR_LINE_CFG)   ? 32'(line_cfg) :
                    (dp_addr == ADDR_LINE_STATE) ? state_view :
                    32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                    hrdata <= 32'h00000000;
    else if (state == BUS_READ_WAIT) hrdata <= rd_value;
  end

  // ---------------- configuration ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable   <= RST_INT_ENABLE;
      polarity     <= RST_POLARITY;
      latch_enable <= RST_LATCH_ENABLE;
      latch_edge   <= RST_LATCH_EDGE;
      line_cfg     <= RST_LINE_CFG;
    end else begin
      if (wr_csr) begin
        int_enable <= hwdata[BIT_INT_ENABLE];
        polarity   <= hwdata[BIT_POLARITY];
      end
      if (wr_group) begin
        latch_enable <= hwdata[BIT_LATCH_ENABLE];
        latch_edge   <= hwdata[BIT_LATCH_EDGE];
      end
      if (wr_line) line_cfg <= hwdata[9:0];
    end
  end

  // lines not in their interrupt role behave as plain I/O
  assign group3_line_c7_out = line_cfg[BIT_C7_OUT];
  assign group3_line_c6_out = line_cfg[BIT_C6_OUT];
  assign group3_line_c7_oe  =
      ~line_cfg[BIT_C7_IRQ_ROLE] & line_cfg[BIT_C7_OE];
  assign group3_line_c6_oe  =
      ~line_cfg[BIT_C6_IRQ_ROLE] & line_cfg[BIT_C6_OE];

  // ---------------- edge qualification ----------------
  wire any_edge  = lines.req_rise | lines.req_fall;
  wire gated     = any_edge & lines.gate_active;
  wire irq_edge  = polarity ? lines.req_fall : lines.req_rise;
  wire irq_hit   = int_enable & gated & irq_edge;
  wire lat_edge  = latch_edge ? lines.req_fall : lines.req_rise;
  wire latch_hit = latch_enable & gated & lat_edge;
  wire acted     = irq_hit | latch_hit;
  wire accept    = acted & ~pending;
  wire ignored   = acted & pending;

  // write-one-to-clear; a set in the same cycle wins
  wire clr_pend  = wr_csr & hwdata[BIT_PENDING];
  wire clr_miss  = wr_csr & hwdata[BIT_MISSED];
  wire clr_rise  = wr_csr & hwdata[BIT_REC_RISE];
  wire clr_fall  = wr_csr & hwdata[BIT_REC_FALL];
  wire clr_edge  = wr_csr & hwdata[BIT_EDGE_STATUS];

  wire next_pending = (pending & ~clr_pend) | accept;
  wire next_missed  = (missed & ~clr_miss) | ignored;
  wire next_rise    = (rec_rise & ~clr_rise) | (accept & lines.req_rise);
  wire next_fall    = (rec_fall & ~clr_fall) | (accept & lines.req_fall);
  wire next_edge    = (edge_status & ~clr_edge) | accept;
  wire next_raised  = (irq_raised & ~clr_pend) | (accept & irq_hit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending     <= 1'b0;
      missed      <= 1'b0;
      rec_rise    <= 1'b0;
      rec_fall    <= 1'b0;
      edge_status <= 1'b0;
      irq_raised  <= 1'b0;
      transfer_q  <= 1'b0;
      latch_q     <= 1'b0;
    end else begin
      pending     <= next_pending;
      missed      <= next_missed;
      rec_rise    <= next_rise;
      rec_fall    <= next_fall;
      edge_status <= next_edge;
      irq_raised  <= next_raised;
      transfer_q  <= accept;
      latch_q     <= accept & latch_hit;
    end
  end

  assign irq_to_host = irq_raised;

  // the shared transfer and latch strobes fan out to every port alike
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_transfer[p] = transfer_q;
      assign port_latch[p]    = latch_q;
    end
  endgenerate

  // ---------------- checks ----------------
  all_ports_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept |=> (&port_transfer))
    else $error("edge did not strobe every port");

  latch_match_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (port_latch != '0) |-> (port_latch == port_transfer))
    else $error("latch strobe differs from transfer");

  pending_blocks_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pending |=> (port_transfer == '0))
    else $error("transfer started while pending");

  missed_first_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pending && acted) |=> missed)
    else $error("blocked edge did not set missed");

  edge_record_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && lines.req_fall) |=>
      (rec_fall && (!rec_rise || $past(rec_rise))))
    else $error("edge record bits wrong");

  host_irq_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && irq_hit) |=> (irq_to_host && (&port_transfer)))
    else $error("interrupt transfer without host interrupt");

  enable_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!int_enable && !irq_raised) |=> !irq_raised)
    else $error("interrupt raised while disabled");

  wrong_polarity_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (int_enable && gated && !irq_raised &&
     (polarity ? lines.req_rise : lines.req_fall)) |=> !irq_raised)
    else $error("opposite edge raised interrupt");

  latch_gate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (port_latch != '0) |-> $past(latch_enable))
    else $error("latch without latch enable");

  edge_status_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!edge_status && !acted) |=> !edge_status)
    else $error("edge status set without action");

  gate_high_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (lines.gate_level || !line_cfg[BIT_C7_IRQ_ROLE]) |=>
      ((port_transfer == '0) && (port_latch == '0)))
    else $error("edge acted with gate inactive");

  reset_rising_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (polarity == 1'b0))
    else $error("polarity not rising after reset");

  // what an accepted edge leaves one cycle later, plus missed-cause, single-strobe, clear, line-drive and read-wait checks
  pend_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept |=> pending)
    else $error("accepted edge did not set pending");

  rise_record_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && lines.req_rise) |=>
      (rec_rise && (!rec_fall || $past(rec_fall))))
    else $error("rise record bits wrong");

  missed_cause_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!missed && !(pending && acted)) |=> !missed)
    else $error("missed set without a blocked edge");

  irq_transfer_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(irq_to_host) |-> (&port_transfer))
    else $error("host interrupt rose without a transfer");

  latch_strobe_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && latch_hit) |=> (&port_latch))
    else $error("latch edge did not strobe every port");

  latch_only_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && !latch_hit) |=> (port_latch == '0))
    else $error("latch strobe on a non-latch edge");

  status_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept |=> edge_status)
    else $error("edge status not set by acted edge");

  strobe_once_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|port_transfer) |=> (port_transfer == '0))
    else $error("transfer strobe lasted more than one cycle");

  pend_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clr_pend && !accept) |=> (!pending && !irq_to_host))
    else $error("pending clear did not drop the interrupt");

  role_oe_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    line_cfg[BIT_C6_IRQ_ROLE] |-> !group3_line_c6_oe)
    else $error("request line driven while in its role");

  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_start |=> !hreadyout ##1 hreadyout)
    else $error("read did not take one wait");
endmodule

// file: hw/ext_irq_pkg.sv
// constants, register map and types of the external request controller
// assumes a 32-bit AHB-Lite bus and a single 100 MHz board clock
package ext_irq_pkg;

  localparam int unsigned NUM_PORTS   = 12;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CLK_MHZ     = 100;

  localparam logic [7:0] ADDR_IRQ_CSR    = 8'h00;
  localparam logic [7:0] ADDR_GROUP_CTRL = 8'h04;
  localparam logic [7:0] ADDR_LINE_CFG   = 8'h08;
  localparam logic [7:0] ADDR_LINE_STATE = 8'h0C;

  // interrupt control/status word
  localparam int unsigned BIT_PENDING     = 0;
  localparam int unsigned BIT_MISSED      = 1;
  localparam int unsigned BIT_REC_RISE    = 2;
  localparam int unsigned BIT_REC_FALL    = 3;
  localparam int unsigned BIT_POLARITY    = 6;
  localparam int unsigned BIT_INT_ENABLE  = 12;
  localparam int unsigned BIT_EDGE_STATUS = 17;

  // group control word
  localparam int unsigned BIT_LATCH_ENABLE = 5;
  localparam int unsigned BIT_LATCH_EDGE   = 6;

  // line configuration word
  localparam int unsigned BIT_C7_IRQ_ROLE = 0;
  localparam int unsigned BIT_C6_IRQ_ROLE = 1;
  localparam int unsigned BIT_C7_OUT      = 4;
  localparam int unsigned BIT_C6_OUT      = 5;
  localparam int unsigned BIT_C7_OE       = 8;
  localparam int unsigned BIT_C6_OE       = 9;

  localparam logic       RST_POLARITY     = 1'b0;
  localparam logic       RST_INT_ENABLE   = 1'b0;
  localparam logic       RST_LATCH_ENABLE = 1'b0;
  localparam logic       RST_LATCH_EDGE   = 1'b0;
  localparam logic [9:0] RST_LINE_CFG     = 10'h000;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } bus_state_t;

endpackage

// file: hw/req_line_if.sv
// carries synchronised request and gate events between the two modules
// assumes both ends run on hclk
`timescale 1ns/1ps
interface req_line_if;
  logic req_rise;
  logic req_fall;
  logic gate_active;
  logic req_level;
  logic gate_level;

  modport detector (output req_rise, req_fall, gate_active,
                    req_level, gate_level);
  modport consumer (input  req_rise, req_fall, gate_active,
                    req_level, gate_level);
endinterface

// file: hw/req_line_sync.sv
// two-flop synchronisers for the request and gate lines, edge detection for the request line
// assumes raw pin levels from outside the clock domain
`timescale 1ns/1ps
module req_line_sync
  import ext_irq_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] raw_lines,
  input  wire logic       role_gate,
  input  wire logic       role_req,
  req_line_if.detector    lines
);
  // index 0 carries the gate line, index 1 the request line
  logic [1:0] meta;
  logic [1:0] synced;
  logic       req_prev;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[i]   <= 1'b1;
          synced[i] <= 1'b1;
        end else begin
          meta[i]   <= raw_lines[i];
          synced[i] <= meta[i];
        end
      end
    end
  endgenerate

  // compare successive synced samples so each edge fires once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) req_prev <= 1'b1;
    else          req_prev <= synced[1];
  end

  assign lines.req_rise    = role_req & synced[1] & ~req_prev;
  assign lines.req_fall    = role_req & ~synced[1] & req_prev;
  assign lines.gate_active = role_gate & ~synced[0];
  assign lines.req_level   = synced[1];
  assign lines.gate_level  = synced[0];

  single_edge_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    lines.req_rise |=> !lines.req_rise)
    else $error("request rise reported twice");
endmodule

// file: tb/ext_irq_edge_latch_ctrl_test.sv
// self-checking bench of the external request edge controller
// assumes the line model in ext_line_driver and a single hclk domain
`timescale 1ns/1ps
module ext_irq_edge_latch_ctrl_test;
  import ext_irq_pkg::*;
  logic                 hclk    = 1'b0;
  logic                 hresetn = 1'b0;
  logic                 hsel    = 1'b0;
  logic [31:0]          haddr   = 32'h0;
  logic [1:0]           htrans  = 2'h0;
  logic                 hwrite  = 1'b0;
  logic [2:0]           hsize   = 3'h2;
  logic [31:0]          hwdata  = 32'h0;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic                 c7_in, c7_out, c7_oe;
  logic                 c6_in, c6_out, c6_oe;
  logic                 irq_to_host;
  logic [NUM_PORTS-1:0] port_transfer;
  logic [NUM_PORTS-1:0] port_latch;
  logic [31:0]          rd, cfg, exp;
  logic                 ie, pol, le, len, g, ri, ai, al;
  int                   failures   = 0;
  int                   num_checks = 0;
  int                   cycles     = 0;
  int                   nx, nl;

  ext_irq_edge_latch_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .group3_line_c7_in(c7_in), .group3_line_c7_out(c7_out),
    .group3_line_c7_oe(c7_oe), .group3_line_c6_in(c6_in),
    .group3_line_c6_out(c6_out), .group3_line_c6_oe(c6_oe),
    .irq_to_host(irq_to_host), .port_transfer(port_transfer),
    .port_latch(port_latch)
  );

  ext_line_driver ext (
    .c7_out(c7_out), .c7_oe(c7_oe), .c6_out(c6_out), .c6_oe(c6_oe),
    .c7_in(c7_in), .c6_in(c6_in)
  );

  initial begin
    forever #5 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run needs about 1800 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      $display("Error %0t: run hung", $time);
      stop_test();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] want,
                            input string what);
    num_checks++;
    if (got !== want) begin
      failures++;
      $display("Error %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  // hsel stays up between calls so no signal is set twice at one edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // strobes are registers, so each edge sample shows the last cycle
  task automatic edge_watch(input logic gv, input logic rv);
    ext.drive(gv, rv);
    nx = 0;
    nl = 0;
    repeat (6) begin
      @(posedge hclk);
      if (port_transfer === {NUM_PORTS{1'b1}}) nx++;
      if (port_latch === {NUM_PORTS{1'b1}}) nl++;
    end
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b0, ADDR_IRQ_CSR, 32'h0);
    check_word(rd, 32'h0, "csr reset");
    check_word(hresp, 1'b0, "okay");
    bus(1'b0, ADDR_GROUP_CTRL, 32'h0);
    check_word(rd, 32'h0, "group reset");
    wr(8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check_word(rd, 32'h0, "unmapped");
    $display("reset test done");

    wr(ADDR_LINE_CFG, 32'h310);
    @(posedge hclk);
    check_word({c7_oe, c6_oe, c7_out, c6_out}, 32'hE, "plain io");
    repeat (3) @(posedge hclk);
    bus(1'b0, ADDR_LINE_STATE, 32'h0);
    check_word(rd & 32'hC, 32'h4, "line state");
    wr(ADDR_LINE_CFG, 32'h313);
    @(posedge hclk);
    check_word({c7_oe, c6_oe}, 32'h0, "role oe");
    $display("line role test done");

    // every combination of enables, edges and gate level
    for (int k = 0; k < 64; k++) begin
      {ie, pol, le, len, g, ri} = k[5:0];
      ai  = !g && ie && (ri != pol);
      al  = !g && len && (ri != le);
      cfg = {19'h0, ie, 5'h0, pol, 6'h0};
      // quiet while the line moves to its start level
      wr(ADDR_IRQ_CSR, 32'h0);
      wr(ADDR_GROUP_CTRL, 32'h0);
      edge_watch(g, !ri);
      wr(ADDR_IRQ_CSR, cfg);
      wr(ADDR_GROUP_CTRL, {25'h0, le, len, 5'h0});
      edge_watch(g, ri);
      // a latch-only edge strobes the ports as well
      check_word(nx, ai || al, "transfer");
      check_word(nl, al, "latch");
      check_word(irq_to_host, ai, "irq");
      exp = cfg | ((ai || al) ? (32'h20001 | (ri ? 32'h4 : 32'h8)) : 32'h0);
      bus(1'b0, ADDR_IRQ_CSR, 32'h0);
      check_word(rd, exp, "csr status");
      wr(ADDR_IRQ_CSR, cfg | 32'h2000F);
      @(posedge hclk);
      check_word(irq_to_host, 1'b0, "irq cleared");
    end
    $display("edge table test done");

    wr(ADDR_IRQ_CSR, 32'h0);
    wr(ADDR_GROUP_CTRL, 32'h0);
    edge_watch(1'b0, 1'b0);
    wr(ADDR_IRQ_CSR, 32'h1000);
    edge_watch(1'b0, 1'b1);
    check_word(nx, 32'h1, "first edge");
    for (int k = 0; k < 2; k++) begin
      edge_watch(1'b0, 1'b0);
      edge_watch(1'b0, 1'b1);
      check_word(nx, 32'h0, "blocked edge");
    end
    bus(1'b0, ADDR_IRQ_CSR, 32'h0);
    check_word(rd, 32'h21007, "missed");
    check_word(irq_to_host, 1'b1, "irq held");
    bus(1'b0, ADDR_LINE_STATE, 32'h0);
    check_word(rd, 32'hB, "line state irq");
    wr(ADDR_IRQ_CSR, 32'h2100F);
    @(posedge hclk);
    check_word(irq_to_host, 1'b0, "irq dropped");
    bus(1'b0, ADDR_IRQ_CSR, 32'h0);
    check_word(rd, 32'h1000, "csr cleared");
    edge_watch(1'b0, 1'b0);
    edge_watch(1'b0, 1'b1);
    check_word(nx, 32'h1, "accepted again");
    $display("pending test done");
    stop_test();
  end
endmodule

// file: tb/ext_line_driver.sv
// model of the outside circuit that drives the gate and request lines
// assumes the bench calls drive() right after a rising hclk edge
`timescale 1ns/1ps
module ext_line_driver (
  input  wire logic c7_out,
  input  wire logic c7_oe,
  input  wire logic c6_out,
  input  wire logic c6_oe,
  output wire logic c7_in,
  output wire logic c6_in
);
  logic gate_n = 1'b1;
  logic req    = 1'b0;
  // design drive wins while its enable is up, no contention modelled
  assign c7_in = c7_oe ? c7_out : gate_n;
  assign c6_in = c6_oe ? c6_out : req;
  // levels stand until the next call; callers space calls >= 2 cycles
  task automatic drive(input logic g, input logic r);
    gate_n <= g;
    req    <= r;
  endtask
endmodule
